// ---- src/gim_defs.vh ----
// Purpose: constants for the global interrupt mask bank 0 block
// Assumes: 8-bit register port, one register per offset
// Notes:   include once; definitions only
`ifndef GIM_DEFS_VH
`define GIM_DEFS_VH

// register offsets
`define GIM_ADDR_MASK0      8'h04
`define GIM_ADDR_FLAGS      8'h00
`define GIM_ADDR_STATUS     8'h03

// mask bit positions
`define GIM_BIT_DROPOUT_R   6
`define GIM_BIT_TALARM2_R   5
`define GIM_BIT_TALARM1_R   4
`define GIM_BIT_EN_R        3
`define GIM_BIT_EN_F        2
`define GIM_BIT_GPIO0_R     1
`define GIM_BIT_GPIO0_F     0

// reset values and widths
`define GIM_MASK_RESET      8'h7F
`define GIM_NUM_SRC         7
`define GIM_STATUS_IRQ_BIT  0

`endif

// ---- src/gim_edge_sync.v ----
// Purpose: three-stage synchroniser with agreement filter and edge pulses
// Assumes: input from outside the clock domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module gim_edge_sync
(
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // raw level in
    input  wire       din,
    // filtered level and edge pulses out
    output reg        level_q,
    output wire       rise,
    output wire       fall
);

    reg       s1_q;
    reg       s2_q;
    reg       s3_q;
    reg       prev_q;
    reg [1:0] fill_q;
    reg       seeded_q;

    // chain; level accepted when stages two and three agree
    // until the third stage holds a real sample the level is seeded without an edge,
    // so a pin that idles high (the active-low enable) fakes no rise after reset
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s1_q     <= 1'b0;
            s2_q     <= 1'b0;
            s3_q     <= 1'b0;
            level_q  <= 1'b0;
            prev_q   <= 1'b0;
            fill_q   <= 2'h0;
            seeded_q <= 1'b0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (!seeded_q)
            begin
                if (fill_q != 2'h3)
                    fill_q <= fill_q + 2'h1;
                else if (s2_q == s3_q)
                begin
                    level_q  <= s3_q;
                    prev_q   <= s3_q;
                    seeded_q <= 1'b1;
                end
            end
            else
            begin
                prev_q <= level_q;
                if (s2_q == s3_q)
                    level_q <= s3_q;
            end
        end
    end

    assign rise = level_q & ~prev_q;
    assign fall = ~level_q & prev_q;

endmodule

`default_nettype wire

// ---- src/gim_top.v ----
// Purpose: interrupt mask bank 0 with event flags and open-drain interrupt output
// Assumes: simple synchronous 8-bit register port, 40 MHz clock
// Notes:   flags clear on read of the flag register; output is open drain
// Functional notes
// - mask bit 6 clear: dropout flag rising pulls interrupt low
// - mask bit 5 clear: thermal alarm two flag rising pulls interrupt low
// - mask bit 4 clear: thermal alarm one flag rising pulls interrupt low
// - mask bit 1 clear: gpio input 0 rising flag rising pulls interrupt low
// - set mask bit blocks its source; bits 6..0 reset to one
// - interrupt stays low until every flag bit is cleared
// - assertion follows each unmasked flag 0-to-1 change, regardless of others
// - flags record events since last read; reading clears them
// - status bit mirrors the gate drive of the interrupt transistor
`timescale 1ns/1ps
`default_nettype none
`include "gim_defs.vh"

module gim_top
(
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // event sources from the device
    input  wire        dropout_in,
    input  wire        thermal_alarm_two_in,
    input  wire        thermal_alarm_one_in,
    input  wire        enable_pin_n,
    input  wire        gpio_in0,
    // open-drain interrupt pin
    output wire        interrupt_out_n,
    output wire        interrupt_out_oe
);

    // position of each pin on the synchroniser bank
    localparam SRC_DROPOUT = 4;
    localparam SRC_TALARM2 = 3;
    localparam SRC_TALARM1 = 2;
    localparam SRC_ENABLE  = 1;
    localparam SRC_GPIO0   = 0;
    localparam NUM_PIN     = 5;

    // registers and their next values
    reg  [7:0] interrupt_mask_global0_q;
    reg  [7:0] interrupt_mask_global0_d;
    reg  [6:0] flags_q;
    reg  [6:0] flags_d;
    reg  [6:0] flags_prev_q;
    reg        irq_drive_q;
    reg        irq_drive_d;
    reg  [7:0] rdata_d;
    // combinational helpers
    wire [6:0] event_w;
    wire [4:0] src_in;
    wire [4:0] src_rise;
    wire [1:0] src_fall;
    wire       rd_flags;
    wire       wr_mask;
    wire [6:0] new_unmasked;

    // address decode used by the strobes
    function addr_hit;
        input [7:0] a;
        input [7:0] target;
        begin
            addr_hit = (a == target);
        end
    endfunction

    // pin levels in synchroniser order
    assign src_in[SRC_DROPOUT] = dropout_in;
    assign src_in[SRC_TALARM2] = thermal_alarm_two_in;
    assign src_in[SRC_TALARM1] = thermal_alarm_one_in;
    assign src_in[SRC_ENABLE]  = enable_pin_n;
    assign src_in[SRC_GPIO0]   = gpio_in0;

    // every source is asynchronous to this clock, so each gets its own synchroniser;
    // only the enable pin and gpio report falling edges, the others leave that pulse open
    genvar g;
    generate
        for (g = 0; g < NUM_PIN; g = g + 1)
        begin : g_sync
            if (g <= SRC_ENABLE)
            begin : g_both
                gim_edge_sync u_sync
                (
                    .clock   (clock),
                    .rst     (rst),
                    .din     (src_in[g]),
                    .level_q (),
                    .rise    (src_rise[g]),
                    .fall    (src_fall[g])
                );
            end
            else
            begin : g_rise
                gim_edge_sync u_sync
                (
                    .clock   (clock),
                    .rst     (rst),
                    .din     (src_in[g]),
                    .level_q (),
                    .rise    (src_rise[g]),
                    .fall    ()
                );
            end
        end
    endgenerate

    // map edges onto flag positions; the two-edge pins share one synchroniser each
    assign event_w[`GIM_BIT_DROPOUT_R] = src_rise[SRC_DROPOUT];
    assign event_w[`GIM_BIT_TALARM2_R] = src_rise[SRC_TALARM2];
    assign event_w[`GIM_BIT_TALARM1_R] = src_rise[SRC_TALARM1];
    assign event_w[`GIM_BIT_EN_R]      = src_rise[SRC_ENABLE];
    assign event_w[`GIM_BIT_EN_F]      = src_fall[SRC_ENABLE];
    assign event_w[`GIM_BIT_GPIO0_R]   = src_rise[SRC_GPIO0];
    assign event_w[`GIM_BIT_GPIO0_F]   = src_fall[SRC_GPIO0];

    // register port strobes; writes to the flag and status offsets are ignored
    assign rd_flags = reg_rd & addr_hit(reg_addr, `GIM_ADDR_FLAGS);
    assign wr_mask  = reg_wr & addr_hit(reg_addr, `GIM_ADDR_MASK0);

    // mask next value; bit 7 is reserved and always stored as zero
    always @*
    begin
        interrupt_mask_global0_d = interrupt_mask_global0_q;
        if (wr_mask)
            interrupt_mask_global0_d = {1'b0, reg_wdata[6:0]};
    end

    // mask register; every source starts masked so nothing fires before software is ready
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            interrupt_mask_global0_q <= `GIM_MASK_RESET;
        else
            interrupt_mask_global0_q <= interrupt_mask_global0_d;
    end

    // sticky flags; an event in the read cycle survives the clear so it is never lost
    always @*
    begin
        flags_d = flags_q;
        if (rd_flags)
            flags_d = 7'h00;
        flags_d = flags_d | event_w;
    end

    // flags and their copy one cycle back, which exposes each 0-to-1 change
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            flags_q      <= 7'h00;
            flags_prev_q <= 7'h00;
        end
        else
        begin
            flags_q      <= flags_d;
            flags_prev_q <= flags_q;
        end
    end

    // a 0-to-1 change of an unmasked flag, judged per bit so flags already set hide nothing;
    // unmasking a flag that is already set gives no change and so no interrupt
    assign new_unmasked = flags_q & ~flags_prev_q & ~interrupt_mask_global0_q[6:0];

    // gate drive next value: a new unmasked flag wins over the release
    always @*
    begin
        irq_drive_d = irq_drive_q;
        if (|new_unmasked)
            irq_drive_d = 1'b1;
        else if (flags_q == 7'h00)
            irq_drive_d = 1'b0;
    end

    // gate drive register; masked flags still hold it once set, since all flags must clear
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            irq_drive_q <= 1'b0;
        else
            irq_drive_q <= irq_drive_d;
    end

    // open drain: the data leg is tied low and the enable carries the interrupt;
    // masked flags never set the drive because new_unmasked excludes them
    assign interrupt_out_n  = 1'b0;
    assign interrupt_out_oe = irq_drive_q;

    // read data next value; unmapped offsets read zero, data holds between reads
    always @*
    begin
        rdata_d = reg_rdata;
        if (reg_rd)
        begin
            case (reg_addr)
                `GIM_ADDR_MASK0:
                    rdata_d = interrupt_mask_global0_q;
                `GIM_ADDR_FLAGS:
                    rdata_d = {1'b0, flags_q};
                `GIM_ADDR_STATUS:
                begin
                    rdata_d = 8'h00;
                    rdata_d[`GIM_STATUS_IRQ_BIT] = irq_drive_q;
                end
                default:
                    rdata_d = 8'h00;
            endcase
        end
    end

    // read data register; status shows the gate drive as it stood at the read edge
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_d;
    end

endmodule

`default_nettype wire

// ---- tb/gim_host_line.sv ----
// Purpose: host side of the open-drain interrupt line
// Assumes: board pull-up on the line
// Notes:   released line reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module gim_host_line
(
    // pin from the block
    input  wire logic oe,
    input  wire logic out_n,
    // level the host sees
    output wire logic line_n
);
    // pull-up wins while nobody sinks the line
    assign line_n = oe ? out_n : 1'b1;
endmodule
`default_nettype wire

// ---- tb/gim_props.sv ----
// Purpose: port-level checks of the mask bank
// Assumes: one clock, async high reset
// Notes:   mask shadow lets reads be judged from the ports alone
`timescale 1ns/1ps
`default_nettype none
module gim_props
(
    // clock, reset and register port
    input  wire logic       clock, rst, reg_wr, reg_rd,
    input  wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    // interrupt pin
    input  wire logic       interrupt_out_n, interrupt_out_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [6:0] mask_q;
    // shadow of the mask register
    always_ff @(posedge clock or posedge rst)
        if (rst) mask_q <= 7'h7F;
        else if (reg_wr && reg_addr == 8'h04) mask_q <= reg_wdata[6:0];
    property p_mask_read; reg_rd && reg_addr == 8'h04 |=> reg_rdata == {1'b0, $past(mask_q)}; endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");
    property p_status_mirror; reg_rd && reg_addr == 8'h03 |=> reg_rdata[0] == $past(interrupt_out_oe); endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status bit wrong");
    property p_unmapped_zero; reg_rd && reg_addr > 8'h04 |=> reg_rdata == 8'h00; endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_fall_after_read; $fell(interrupt_out_oe) |-> $past(reg_rd, 2) && $past(reg_addr, 2) == 8'h00; endproperty
    a_fall_after_read: assert property (p_fall_after_read) else $error("irq released early");
    property p_masked_quiet; mask_q == 7'h7F && $past(mask_q) == 7'h7F |=> !$rose(interrupt_out_oe); endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked irq");
    property p_oe_data_low; interrupt_out_oe |-> !interrupt_out_n; endproperty
    a_oe_data_low: assert property (p_oe_data_low) else $error("pin data high");
    property p_rdata_reset; $fell(rst) |-> reg_rdata == 8'h00; endproperty
    a_rdata_reset: assert property (p_rdata_reset) else $error("read data not reset");
    c_irq: cover property ($rose(interrupt_out_oe));
    c_clear: cover property ($fell(interrupt_out_oe));
    c_status: cover property (reg_rd && reg_addr == 8'h03);
endmodule
bind gim_top gim_props u_props (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n),
    .interrupt_out_oe(interrupt_out_oe));
`default_nettype wire

// ---- tb/global_interrupt_mask_bank0_tb.sv ----
// Purpose: self-checking bench for the mask bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   one event per t_event test so each flag is judged alone; t_stacked combines several
`timescale 1ns/1ps
`default_nettype none
module global_interrupt_mask_bank0_tb;
    logic       clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic [4:0] pins = 5'h00; // dropout, alarm two, alarm one, enable, gpio
    wire        oe, out_n, line_n;
    int         n_mismatch = 0, num_checks = 0, cyc = 0;
    always #12.5 clock = ~clock;
    gim_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dropout_in(pins[4]), .thermal_alarm_two_in(pins[3]),
        .thermal_alarm_one_in(pins[2]), .enable_pin_n(pins[1]), .gpio_in0(pins[0]),
        .interrupt_out_n(out_n), .interrupt_out_oe(oe));
    gim_host_line host (.oe(oe), .out_n(out_n), .line_n(line_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin n_mismatch++; $display("MISMATCH %0t got %h want %h", $time, got, exp); end
    endtask
    // one strobe cycle; read data is taken once the answer has landed
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        reg_addr = a; reg_wdata = d; reg_wr = wr; reg_rd = !wr;
        @(posedge clock) #1;
        reg_wr = 0; reg_rd = 0; rv = reg_rdata;
    endtask
    task automatic t_reset;
        acc(0, 8'h04, 8'h00); chk(rv, 8'h7F);
        acc(0, 8'h03, 8'h00); chk(rv, 8'h00);
        acc(0, 8'h30, 8'h00); chk(rv, 8'h00);
        $display("test reset done");
    endtask
    // toggle the pin behind flag i with only that source unmasked, or all masked
    task automatic t_event(input int i, input logic masked);
        int k;
        logic [7:0] b;
        b = 8'h01 << i;
        acc(1, 8'h04, masked ? 8'h7F : ~b & 8'h7F);
        acc(0, 8'h00, 8'h00);
        pins[i >= 4 ? i - 2 : i / 2] ^= 1'b1;
        k = 0;
        while (line_n !== 1'b0 && k < 20) begin @(posedge clock); k++; end
        chk({7'h00, line_n}, {7'h00, masked});
        acc(0, 8'h03, 8'h00); chk(rv & 8'h01, {7'h00, !masked});
        acc(0, 8'h00, 8'h00); chk(rv, b);
        repeat (2) @(posedge clock); #1;
        chk({7'h00, line_n}, 8'h01);
        acc(0, 8'h00, 8'h00); chk(rv, 8'h00);
        $display("test event %0d masked %0b done", i, masked);
    endtask
    // a masked flag already set neither fires on unmask nor hides a later unmasked rise
    task automatic t_stacked;
        int k;
        acc(1, 8'h04, 8'h7D); // only gpio rise unmasked
        acc(0, 8'h00, 8'h00);
        pins[1] = 1'b1; // enable rise, masked
        repeat (8) @(posedge clock); #1;
        chk({7'h00, line_n}, 8'h01);
        acc(1, 8'h04, 8'h75); // unmask enable rise while its flag is already set
        repeat (4) @(posedge clock); #1;
        chk({7'h00, line_n}, 8'h01);
        pins[0] = 1'b1; // gpio rise, unmasked
        k = 0;
        while (line_n !== 1'b0 && k < 20) begin @(posedge clock); k++; end
        chk({7'h00, line_n}, 8'h00);
        acc(0, 8'h00, 8'h00); chk(rv, 8'h0A);
        repeat (2) @(posedge clock); #1;
        chk({7'h00, line_n}, 8'h01);
        pins[1:0] = 2'h0; // both falls, on masked bits 2 and 0
        repeat (8) @(posedge clock); #1;
        chk({7'h00, line_n}, 8'h01);
        acc(0, 8'h00, 8'h00); chk(rv, 8'h05);
        $display("test stacked done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clock) begin cyc++; if (cyc > 3000) begin n_mismatch++; give_verdict; end end
    initial
    begin
        repeat (10) @(posedge clock);
        #1 rst = 0;
        t_reset;
        for (int i = 3; i >= 0; i--) t_event(i, 1'b1);
        for (int i = 6; i >= 0; i--) t_event(i, 1'b0);
        t_stacked;
        give_verdict;
    end
endmodule
`default_nettype wire
